// ===== pkg/spcr_pkg.sv
package spcr_pkg;
   // Register offsets within the capability block
   localparam logic [7:0] SPCR_OFF_COMMAND = 8'h02;
   localparam logic [7:0] SPCR_OFF_MASK = 8'h04;
   localparam logic [7:0] SPCR_OFF_ROUTING = 8'h08;
   localparam logic [7:0] SPCR_OFF_COUNTER = 8'h0c;
   localparam logic [7:0] SPCR_OFF_RANGE = 8'h10;
   localparam logic [7:0] SPCR_OFF_XLATE = 8'h14;
   // Switch command fields (16-bit register)
   localparam int SPCR_CMD_ABORT_FLAG = 7;
   localparam int SPCR_CMD_FLOOD_ON = 8;
   localparam int SPCR_CMD_FATAL_ON = 9;
   localparam int SPCR_CMD_MINOR_ON = 10;
   localparam logic [4:0] SPCR_CAP_TYPE = 5'h08;
   // Routing info fields
   localparam int SPCR_RT_DECODE_EN = 5;
   localparam int SPCR_RT_COLD_SEL = 6;
   localparam int SPCR_RT_CNT_LSB = 8;
   localparam int SPCR_RT_WIN_LSB = 16;
   localparam int SPCR_RT_PIN = 22;
   localparam int SPCR_RT_CONCEAL = 23;
   // Sizes
   localparam int SPCR_NUM_PORTS = 32;
   localparam int SPCR_NUM_COUNTERS = 12;
   localparam int SPCR_NUM_RANGES = 16;
   localparam int SPCR_GRAN_BITS = 24;
   // Reset values
   localparam logic [4:0] SPCR_RST_FALLBACK = 5'h00;
   localparam logic [31:0] SPCR_ZERO32 = 32'h0000_0000;
   localparam logic [31:0] SPCR_ONES32 = 32'hffff_ffff;
   localparam logic [39:0] SPCR_HI_ONES = 40'hff_ffff_ffff;
   // Counter slot indices
   localparam int SPCR_CNT_RX_DW = 3;
   localparam int SPCR_CNT_TX_CMD = 6;
   localparam int SPCR_CNT_TX_DW = 9;
endpackage

// ===== src/spcr_regs.sv
`timescale 1ns/1ns
// Summary of operation
// - Abort flag sets on posted abort, W1C
// - Sync flood needs flood and serr enables
// - Fatal interrupt gated by fatal enable
// - Nonfatal interrupt gated by nonfatal enable
// - Command top bits read capability type 01000b
// - Mask enables ports, own bit one
// - Mask resets ones, applies after reset/halt
// - Fallback port persists, applies after reset/halt
// - Decode off forwards non-config requests to fallback port, primary only
// - Never forward outside ingress partition
// - Cold select makes bus reset cold
// - Counter select picks counter, reserved zero
// - Counter read clears, counters saturate
// - Selects 0-5 receive, 6-B transmit
// - Window select upper bits pick pair
// - Window select low bits pick doubleword
// - 64-bit ranges, 16MB granules, enable bit
// - Unimplemented pairs read limit zero base ones
// - Secondary base translates matching range
// - Pin state live on secondary only; conceal aborts internal-bus config, primary only
module spcr_regs
   import spcr_pkg::*;
#(
   parameter logic [4:0] OWN_PORT = 5'd0,
   parameter logic [31:0] IMPL_PORTS = 32'h0000_000f,
   parameter logic [15:0] IMPL_RANGES = 16'h000f,
   parameter logic IS_PRIMARY = 1'b1
)
(
   // Clock and resets
   input wire logic clock,
   input wire logic resetn,
   input wire logic warm_reset,
   input wire logic link_halt_event,
   // Configuration access
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_addr,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   // Error events
   input wire logic posted_abort,
   input wire logic system_error_report_on,
   output logic sync_flood,
   output logic fatal_irq,
   output logic minor_irq,
   // Traffic events: posted, nonposted, response; dw counts per packet
   input wire logic [2:0] rx_pkt,
   input wire logic [2:0] tx_pkt,
   input wire logic [2:0][4:0] rx_dw,
   input wire logic [2:0][4:0] tx_dw,
   // Routing
   input wire logic [4:0] ingress_port,
   input wire logic req_is_cfg,
   input wire logic req_from_int_bus,
   input wire logic [63:0] req_addr,
   output logic route_to_fallback,
   output logic route_master_abort,
   output logic [SPCR_NUM_RANGES-1:0] range_hit,
   output logic [63:0] xlate_addr,
   output logic [SPCR_NUM_PORTS-1:0] active_port_mask,
   output logic [4:0] active_fallback,
   // Reset control
   input wire logic bus_reset_start,
   output logic cold_reset_req,
   output logic power_good_out,
   // Insertion pin
   input wire logic insertion_pin_n
);
   logic abort_flag, flood_on, fatal_on, minor_on;
   logic decode_en, cold_sel, conceal;
   logic [3:0] cnt_sel;
   logic [5:0] win_sel;
   logic [4:0] fallback;
   logic [31:0] mask_reg;
   logic [31:0] cnt [SPCR_NUM_COUNTERS];
   logic [63:0] rbase [SPCR_NUM_RANGES];
   logic [63:0] rlim [SPCR_NUM_RANGES];
   logic [63:0] sbase [SPCR_NUM_RANGES];
   logic pin_s1, pin_s2;
   logic next_abort_flag, next_flood_on, next_fatal_on, next_minor_on;
   logic next_decode_en, next_cold_sel, next_conceal;
   logic [3:0] next_cnt_sel;
   logic [5:0] next_win_sel;
   logic [4:0] next_fallback, next_active_fallback;
   logic [31:0] next_mask_reg, next_active_port_mask, next_cfg_rdata;
   logic wr_cmd, wr_mask, wr_rt, wr_cnt, wr_rng, wr_xl, rd_cnt;
   logic [31:0] mask_fixed;
   localparam logic [31:0] MASK_RST = IMPL_PORTS | (32'h0000_0001 << OWN_PORT);

   function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++)
         if (be[i])
            r[i*8 +: 8] = new_v[i*8 +: 8];
      return r;
   endfunction

   assign wr_cmd = cfg_wr && cfg_addr == 8'h00;
   assign wr_mask = cfg_wr && cfg_addr == SPCR_OFF_MASK;
   assign wr_rt = cfg_wr && cfg_addr == SPCR_OFF_ROUTING;
   assign wr_cnt = cfg_wr && cfg_addr == SPCR_OFF_COUNTER;
   assign wr_rng = cfg_wr && cfg_addr == SPCR_OFF_RANGE;
   assign wr_xl = cfg_wr && cfg_addr == SPCR_OFF_XLATE;
   assign rd_cnt = cfg_rd && cfg_addr == SPCR_OFF_COUNTER;
   // Own bit forced to one, absent ports zero
   assign mask_fixed = (mask_reg & IMPL_PORTS) | (32'h0000_0001 << OWN_PORT);

   // Control bits: command word sits in bytes 2-3 of dword 0
   always_comb
   begin
      logic [31:0] cw, rw;
      cw = be_merge(32'h0000_0000, cfg_wdata, cfg_be);
      rw = be_merge({8'h00, conceal, 1'b0, win_sel, 4'h0, cnt_sel, 1'b0, cold_sel, decode_en,
                     fallback}, cfg_wdata, cfg_be);
      next_abort_flag = abort_flag;
      next_flood_on = flood_on;
      next_fatal_on = fatal_on;
      next_minor_on = minor_on;
      next_decode_en = decode_en;
      next_cold_sel = cold_sel;
      next_conceal = conceal;
      next_cnt_sel = cnt_sel;
      next_win_sel = win_sel;
      next_fallback = fallback;
      next_mask_reg = mask_reg;
      if (wr_cmd)
      begin
         if (cfg_be[2] && cfg_wdata[16 + SPCR_CMD_ABORT_FLAG])
            next_abort_flag = 1'b0;
         if (cfg_be[3])
         begin
            next_flood_on = cw[16 + SPCR_CMD_FLOOD_ON];
            next_fatal_on = cw[16 + SPCR_CMD_FATAL_ON];
            next_minor_on = cw[16 + SPCR_CMD_MINOR_ON];
         end
      end
      if (posted_abort)
         next_abort_flag = 1'b1;
      if (wr_mask)
         next_mask_reg = be_merge(mask_reg, cfg_wdata, cfg_be) & IMPL_PORTS;
      if (wr_rt)
      begin
         next_fallback = rw[4:0];
         next_decode_en = IS_PRIMARY & rw[SPCR_RT_DECODE_EN];
         next_cold_sel = rw[SPCR_RT_COLD_SEL];
         next_cnt_sel = rw[SPCR_RT_CNT_LSB +: 4];
         next_win_sel = rw[SPCR_RT_WIN_LSB +: 6];
         next_conceal = IS_PRIMARY & rw[SPCR_RT_CONCEAL];
      end
      // Latched copies of mask and fallback only refresh at reset or halt
      next_active_port_mask = active_port_mask;
      next_active_fallback = active_fallback;
      if (link_halt_event || warm_reset)
      begin
         next_active_port_mask = mask_fixed;
         next_active_fallback = fallback;
      end
      if (warm_reset)
      begin
         next_flood_on = 1'b0;
         next_fatal_on = 1'b0;
         next_minor_on = 1'b0;
         next_decode_en = 1'b0;
         next_cold_sel = 1'b0;
         next_cnt_sel = 4'h0;
         next_win_sel = 6'h00;
      end
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         abort_flag <= 1'b0;
         flood_on <= 1'b0;
         fatal_on <= 1'b0;
         minor_on <= 1'b0;
         decode_en <= 1'b0;
         cold_sel <= 1'b0;
         conceal <= 1'b0;
         cnt_sel <= 4'h0;
         win_sel <= 6'h00;
         fallback <= SPCR_RST_FALLBACK;
         mask_reg <= MASK_RST;
         active_port_mask <= MASK_RST;
         active_fallback <= SPCR_RST_FALLBACK;
      end
      else
      begin
         abort_flag <= next_abort_flag;
         flood_on <= next_flood_on;
         fatal_on <= next_fatal_on;
         minor_on <= next_minor_on;
         decode_en <= next_decode_en;
         cold_sel <= next_cold_sel;
         conceal <= next_conceal;
         cnt_sel <= next_cnt_sel;
         win_sel <= next_win_sel;
         fallback <= next_fallback;
         mask_reg <= next_mask_reg;
         active_port_mask <= next_active_port_mask;
         active_fallback <= next_active_fallback;
      end
   end

   // Traffic counters
   generate
      for (genvar g = 0; g < SPCR_NUM_COUNTERS; g++)
      begin : g_cnt
         logic [31:0] next_c;
         logic [5:0] inc;
         logic [32:0] sum;
         always_comb
         begin
            if (g < SPCR_NUM_COUNTERS / 2)
               inc = (g < SPCR_CNT_RX_DW) ? {5'h00, rx_pkt[g % 3]} :
                     (rx_pkt[g % 3] ? {1'b0, rx_dw[g % 3]} : 6'h00);
            else
               inc = (g < SPCR_CNT_TX_DW) ? {5'h00, tx_pkt[g % 3]} :
                     (tx_pkt[g % 3] ? {1'b0, tx_dw[g % 3]} : 6'h00);
            // Read clears but the same-cycle increment survives
            sum = {1'b0, (rd_cnt && cnt_sel == 4'(g)) ? 32'h0000_0000 : cnt[g]}
                  + {27'h000_0000, inc};
            next_c = sum[32] ? SPCR_ONES32 : sum[31:0];
            if (wr_cnt && cnt_sel == 4'(g))
               next_c = be_merge(cnt[g], cfg_wdata, cfg_be);
            if (warm_reset)
               next_c = SPCR_ZERO32;
         end
         always_ff @(posedge clock or negedge resetn)
         begin
            if (!resetn)
               cnt[g] <= 32'h0000_0000;
            else
               cnt[g] <= next_c;
         end
      end
   endgenerate

   // Base/limit ranges and secondary bases
   generate
      for (genvar r = 0; r < SPCR_NUM_RANGES; r++)
      begin : g_rng
         logic [63:0] next_b, next_l, next_s;
         logic sel;
         assign sel = win_sel[5:2] == 4'(r) && IMPL_RANGES[r];
         always_comb
         begin
            next_b = rbase[r];
            next_l = rlim[r];
            next_s = sbase[r];
            if (wr_rng && sel)
               case (win_sel[1:0])
                  2'd0: next_b[31:0] = be_merge(rbase[r][31:0], cfg_wdata, cfg_be);
                  2'd1: next_b[63:32] = be_merge(rbase[r][63:32], cfg_wdata, cfg_be);
                  2'd2: next_l[31:0] = be_merge(rlim[r][31:0], cfg_wdata, cfg_be);
                  default: next_l[63:32] = be_merge(rlim[r][63:32], cfg_wdata, cfg_be);
               endcase
            if (wr_xl && sel)
            begin
               if (win_sel[1])
                  next_s[63:32] = be_merge(sbase[r][63:32], cfg_wdata, cfg_be);
               else
                  next_s[31:0] = be_merge(sbase[r][31:0], cfg_wdata, cfg_be);
            end
            // Reserved granule bits stay zero, bit 0 is the enable in base and secondary base, limit bit 0 is zero
            next_b[23:1] = 23'h00_0000;
            next_l[23:0] = 24'h00_0000;
            next_s[23:1] = 23'h00_0000;
            if (warm_reset)
            begin
               next_b = 64'h0000_0000_0000_0000;
               next_l = 64'h0000_0000_0000_0000;
               next_s = 64'h0000_0000_0000_0000;
            end
         end
         always_ff @(posedge clock or negedge resetn)
         begin
            if (!resetn)
            begin
               rbase[r] <= 64'h0000_0000_0000_0000;
               rlim[r] <= 64'h0000_0000_0000_0000;
               sbase[r] <= 64'h0000_0000_0000_0000;
            end
            else
            begin
               rbase[r] <= next_b;
               rlim[r] <= next_l;
               sbase[r] <= next_s;
            end
         end
         // Limit low bits taken as ones for the compare
         assign range_hit[r] = IMPL_RANGES[r] && rbase[r][0]
            && req_addr[63:SPCR_GRAN_BITS] >= rbase[r][63:SPCR_GRAN_BITS]
            && req_addr[63:SPCR_GRAN_BITS] <= rlim[r][63:SPCR_GRAN_BITS];
      end
   endgenerate

   // Translation by secondary base minus range base
   always_comb
   begin
      xlate_addr = req_addr;
      for (int r = 0; r < SPCR_NUM_RANGES; r++)
         if (range_hit[r] && sbase[r][0])
            xlate_addr = req_addr + {sbase[r][63:SPCR_GRAN_BITS], 24'h00_0000}
                         - {rbase[r][63:SPCR_GRAN_BITS], 24'h00_0000};
   end

   // Forwarding decisions
   always_comb
   begin
      logic fb_ok, ingress_ok;
      fb_ok = active_port_mask[active_fallback];
      ingress_ok = active_port_mask[ingress_port];
      route_to_fallback = IS_PRIMARY && !decode_en && !req_is_cfg && fb_ok && ingress_ok;
      route_master_abort = (IS_PRIMARY && !decode_en && !req_is_cfg && !(fb_ok && ingress_ok))
         || (IS_PRIMARY && conceal && req_is_cfg && req_from_int_bus);
   end

   assign sync_flood = abort_flag && flood_on && system_error_report_on;
   assign fatal_irq = abort_flag && fatal_on;
   assign minor_irq = abort_flag && minor_on;
   assign cold_reset_req = bus_reset_start && cold_sel;
   assign power_good_out = !cold_reset_req;

   // Pin synchroniser
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         pin_s1 <= 1'b1;
         pin_s2 <= 1'b1;
      end
      else
      begin
         pin_s1 <= insertion_pin_n;
         pin_s2 <= pin_s1;
      end
   end

   // Read mux
   always_comb
   begin
      logic [63:0] b, l, s;
      logic ok;
      ok = IMPL_RANGES[win_sel[5:2]];
      b = ok ? rbase[win_sel[5:2]] : {SPCR_HI_ONES, 24'hff_ffff};
      l = ok ? rlim[win_sel[5:2]] : 64'h0000_0000_0000_0000;
      s = ok ? sbase[win_sel[5:2]] : 64'h0000_0000_0000_0000;
      case (cfg_addr)
         8'h00: next_cfg_rdata = {SPCR_CAP_TYPE, minor_on, fatal_on, flood_on, abort_flag,
                                  7'h00, 16'h0000};
         SPCR_OFF_MASK: next_cfg_rdata = mask_fixed;
         SPCR_OFF_ROUTING: next_cfg_rdata = {8'h00, conceal, IS_PRIMARY ? 1'b0 : pin_s2,
                                  win_sel, 4'h0, cnt_sel, 1'b0, cold_sel, decode_en, fallback};
         SPCR_OFF_COUNTER: next_cfg_rdata = (cnt_sel < 4'(SPCR_NUM_COUNTERS)) ? cnt[cnt_sel]
                                            : SPCR_ZERO32;
         SPCR_OFF_RANGE:
            case (win_sel[1:0])
               2'd0: next_cfg_rdata = b[31:0];
               2'd1: next_cfg_rdata = b[63:32];
               2'd2: next_cfg_rdata = ok ? (l[31:0] | 32'h00ff_ffff) : l[31:0];
               default: next_cfg_rdata = l[63:32];
            endcase
         SPCR_OFF_XLATE: next_cfg_rdata = win_sel[1] ? s[63:32] : s[31:0];
         default: next_cfg_rdata = SPCR_ZERO32;
      endcase
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         cfg_rdata <= 32'h0000_0000;
      else if (cfg_rd)
         cfg_rdata <= next_cfg_rdata;
   end
endmodule

// ===== test/spcr_regs_chk.sv
`timescale 1ns/1ns
module spcr_regs_chk
   import spcr_pkg::*;
#(
   parameter logic [4:0] OWN_PORT = 5'd0,
   parameter logic [31:0] IMPL_PORTS = 32'h0000_000f
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic resetn,
   // Observed ports
   input wire logic warm_reset,
   input wire logic link_halt_event,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_addr,
   input wire logic [31:0] cfg_rdata,
   input wire logic system_error_report_on,
   input wire logic sync_flood,
   input wire logic req_is_cfg,
   input wire logic route_to_fallback,
   input wire logic [SPCR_NUM_PORTS-1:0] active_port_mask,
   input wire logic [4:0] active_fallback,
   input wire logic bus_reset_start,
   input wire logic cold_reset_req,
   input wire logic power_good_out
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);
   sequence s_cmd_read;
      cfg_rd && (cfg_addr == 8'h00);
   endsequence
   property p_cap_type;
      s_cmd_read |=> (cfg_rdata[31:27] == SPCR_CAP_TYPE);
   endproperty
   a_cap_type: assert property (p_cap_type) else $error("cap type wrong");
   property p_rdata_hold;
      !cfg_rd |=> $stable(cfg_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
   property p_flood_serr;
      sync_flood |-> system_error_report_on;
   endproperty
   a_flood_serr: assert property (p_flood_serr) else $error("flood no serr");
   property p_own_port;
      active_port_mask[OWN_PORT] && ((active_port_mask & ~IMPL_PORTS) == 32'h0000_0000);
   endproperty
   a_own_port: assert property (p_own_port) else $error("mask bits wrong");
   property p_mask_hold;
      !link_halt_event && !warm_reset |=> $stable(active_port_mask);
   endproperty
   a_mask_hold: assert property (p_mask_hold) else $error("mask moved");
   property p_fb_hold;
      !link_halt_event && !warm_reset |=> $stable(active_fallback);
   endproperty
   a_fb_hold: assert property (p_fb_hold) else $error("fallback moved");
   property p_cfg_route;
      req_is_cfg |-> !route_to_fallback;
   endproperty
   a_cfg_route: assert property (p_cfg_route) else $error("cfg sent to fallback");
   property p_partition;
      route_to_fallback |-> active_port_mask[active_fallback];
   endproperty
   a_partition: assert property (p_partition) else $error("outside partition");
   property p_cold_req;
      cold_reset_req |-> bus_reset_start && !power_good_out;
   endproperty
   a_cold_req: assert property (p_cold_req) else $error("cold request wrong");
   property p_power_good;
      !bus_reset_start |-> power_good_out;
   endproperty
   a_power_good: assert property (p_power_good) else $error("power good low");
endmodule
bind spcr_regs spcr_regs_chk #(.OWN_PORT(OWN_PORT), .IMPL_PORTS(IMPL_PORTS)) u_chk (
   .clock(clock), .resetn(resetn), .warm_reset(warm_reset),
   .link_halt_event(link_halt_event), .cfg_rd(cfg_rd),
   .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata), .system_error_report_on(system_error_report_on),
   .sync_flood(sync_flood), .req_is_cfg(req_is_cfg), .route_to_fallback(route_to_fallback),
   .active_port_mask(active_port_mask), .active_fallback(active_fallback),
   .bus_reset_start(bus_reset_start), .cold_reset_req(cold_reset_req),
   .power_good_out(power_good_out));

// ===== test/tb_switch_port_capability_regs.sv
`timescale 1ns/1ns
module tb_switch_port_capability_regs;
   import spcr_pkg::*;
   // Command word shares dword 0 with the capability header
   localparam logic [7:0] CMD_ADDR = {SPCR_OFF_COMMAND[7:2], 2'b00};
   logic clock, resetn, warm_reset, link_halt_event, cfg_wr, cfg_rd, posted_abort;
   logic [7:0] cfg_addr;
   logic [3:0] cfg_be;
   logic [31:0] cfg_wdata, cfg_rdata, v, m, active_port_mask;
   logic system_error_report_on, sync_flood, fatal_irq, minor_irq;
   logic [2:0] rx_pkt, tx_pkt;
   logic [2:0][4:0] rx_dw, tx_dw;
   logic [4:0] ingress_port, active_fallback, fb;
   logic req_is_cfg, req_from_int_bus, route_to_fallback, route_master_abort;
   logic [63:0] req_addr, xlate_addr;
   logic [15:0] range_hit;
   logic bus_reset_start, cold_reset_req, power_good_out, insertion_pin_n;
   logic [31:0] cnt [12];
   logic [31:0] rng [4] = '{32'h1, 32'h1, 32'h0, 32'h1};
   int error_cnt, num_checks;
   spcr_regs uut (.clock, .resetn, .warm_reset, .link_halt_event, .cfg_wr, .cfg_rd, .cfg_addr,
      .cfg_be, .cfg_wdata, .cfg_rdata, .posted_abort, .system_error_report_on, .sync_flood,
      .fatal_irq, .minor_irq, .rx_pkt, .tx_pkt, .rx_dw, .tx_dw, .ingress_port, .req_is_cfg,
      .req_from_int_bus, .req_addr, .route_to_fallback, .route_master_abort, .range_hit,
      .xlate_addr, .active_port_mask, .active_fallback, .bus_reset_start, .cold_reset_req,
      .power_good_out, .insertion_pin_n);
   function automatic logic [31:0] exp_win(input int p, input int d, input logic [31:0] w);
      if (p > 3)
         return (d < 2) ? 32'hffff_ffff : 32'h0000_0000;
      if (d == 0)
         return w & 32'hff00_0001;
      return (d == 2) ? (w | 32'h00ff_ffff) : w;
   endfunction
   task automatic chk_val(input string what, input logic [63:0] e, input logic [63:0] g);
      num_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic chk_bit(input string what, input logic e, input logic g);
      chk_val(what, {63'h0, e}, {63'h0, g});
   endtask
   task automatic tick;
      @(negedge clock);
   endtask
   task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      tick;
      cfg_wr = 1;
      cfg_addr = a;
      cfg_be = be;
      cfg_wdata = d;
      tick;
      cfg_wr = 0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      tick;
      cfg_rd = 1;
      cfg_addr = a;
      tick;
      cfg_rd = 0;
      d = cfg_rdata;
   endtask
   task automatic set_win(input int p, input int d);
      wr(SPCR_OFF_ROUTING, 4'b0100, 32'({p[3:0], d[1:0]}) << 16);
   endtask
   task automatic halt;
      tick;
      link_halt_event = 1;
      tick;
      link_halt_event = 0;
   endtask
   task automatic warm;
      tick;
      warm_reset = 1;
      tick;
      warm_reset = 0;
   endtask
   task automatic abort_pulse;
      tick;
      posted_abort = 1;
      tick;
      posted_abort = 0;
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      clock = 0;
      forever #50 clock = ~clock;
   end
   initial
   begin
      {resetn, warm_reset, link_halt_event, cfg_wr, cfg_rd, posted_abort, req_is_cfg} = '0;
      {cfg_addr, cfg_be, cfg_wdata, rx_pkt, tx_pkt, rx_dw, tx_dw, ingress_port} = '0;
      {system_error_report_on, req_from_int_bus, req_addr, bus_reset_start} = '0;
      insertion_pin_n = 1;
      void'($urandom(99073));
      repeat (20) tick;
      resetn = 1;
      // Reset values and an unmapped place
      rd(SPCR_OFF_MASK, v);
      chk_val("mask reset", 32'h0000_000f, v);
      rd(SPCR_OFF_ROUTING, v);
      chk_val("routing reset", 32'h0000_0000, v);
      wr(8'h18, 4'hf, 32'hffff_ffff);
      rd(8'h18, v);
      chk_val("unmapped", 32'h0000_0000, v);
      $display("test reset done");
      // Abort flag and its reporting enables
      abort_pulse;
      rd(CMD_ADDR, v);
      chk_val("command", 16'h4080, v[31:16]);
      for (int e = 0; e < 8; e++)
      begin
         system_error_report_on = 1'($urandom);
         wr(CMD_ADDR, 4'b1000, 32'(e) << 24);
         chk_bit("sync flood", e[0] & system_error_report_on, sync_flood);
         chk_bit("fatal irq", e[1], fatal_irq);
         chk_bit("minor irq", e[2], minor_irq);
      end
      wr(CMD_ADDR, 4'b0100, 32'h0080_0000);
      chk_bit("fatal after clear", 0, fatal_irq);
      abort_pulse;
      warm;
      rd(CMD_ADDR, v);
      chk_val("command warm", 9'h081, v[31:23]);
      $display("test abort done");
      // Mask and fallback take effect only on a halt event or warm reset
      m = $urandom;
      fb = 5'($urandom);
      wr(SPCR_OFF_MASK, 4'hf, m);
      wr(SPCR_OFF_ROUTING, 4'b0001, 32'(fb));
      chk_val("active mask", 32'h0000_000f, active_port_mask);
      chk_val("active fallback", 5'h00, active_fallback);
      halt;
      chk_val("active mask", (m & 32'h0000_000f) | 32'h0000_0001, active_port_mask);
      chk_val("active fallback", fb, active_fallback);
      warm;
      rd(SPCR_OFF_MASK, v);
      chk_val("mask warm", (m & 32'h0000_000f) | 32'h0000_0001, v);
      rd(SPCR_OFF_ROUTING, v);
      chk_val("fallback warm", fb, v[4:0]);
      $display("test mask done");
      // Decode off: fallback inside and outside the partition
      for (int i = 0; i < 2; i++)
      begin
         wr(SPCR_OFF_MASK, 4'hf, 32'h0000_0005);
         wr(SPCR_OFF_ROUTING, 4'b0001, (i == 0) ? 32'h0000_0002 : 32'h0000_0001);
         halt;
         chk_bit("to fallback", i == 0, route_to_fallback);
         chk_bit("master abort", i != 0, route_master_abort);
         req_is_cfg = 1;
         tick;
         chk_bit("cfg to fallback", 0, route_to_fallback);
         req_is_cfg = 0;
      end
      for (int i = 0; i < 2; i++)
      begin
         wr(SPCR_OFF_ROUTING, 4'b0001, (i == 0) ? 32'h0000_0040 : 32'h0000_0000);
         bus_reset_start = 1;
         tick;
         chk_bit("cold request", i == 0, cold_reset_req);
         chk_bit("power good", i != 0, power_good_out);
         bus_reset_start = 0;
      end
      // Concealed port: config from the internal bus aborts, other config does not
      wr(SPCR_OFF_ROUTING, 4'b0100, 32'h0080_0000);
      req_is_cfg = 1;
      req_from_int_bus = 1;
      tick;
      chk_bit("conceal abort", 1, route_master_abort);
      req_from_int_bus = 0;
      tick;
      chk_bit("conceal other source", 0, route_master_abort);
      req_is_cfg = 0;
      wr(SPCR_OFF_ROUTING, 4'b0100, 32'h0000_0000);
      $display("test routing done");
      // Traffic counters: clear, random traffic, read, read again
      for (int s = 0; s < 12; s++)
      begin
         wr(SPCR_OFF_ROUTING, 4'b0010, 32'(s) << 8);
         rd(SPCR_OFF_COUNTER, v);
         cnt[s] = 0;
      end
      for (int k = 0; k < 20; k++)
      begin
         tick;
         rx_pkt = 3'($urandom);
         tx_pkt = 3'($urandom);
         for (int c = 0; c < 3; c++)
         begin
            rx_dw[c] = rx_pkt[c] ? 5'($urandom) : 5'h00;
            tx_dw[c] = tx_pkt[c] ? 5'($urandom) : 5'h00;
            cnt[c] += rx_pkt[c];
            cnt[3 + c] += rx_dw[c];
            cnt[6 + c] += tx_pkt[c];
            cnt[9 + c] += tx_dw[c];
         end
      end
      tick;
      {rx_pkt, tx_pkt, rx_dw, tx_dw} = '0;
      for (int s = 0; s < 16; s++)
      begin
         wr(SPCR_OFF_ROUTING, 4'b0010, 32'(s) << 8);
         rd(SPCR_OFF_COUNTER, v);
         chk_val("counter", (s < 12) ? cnt[s] : 32'h0000_0000, v);
         rd(SPCR_OFF_COUNTER, v);
         chk_val("counter cleared", 32'h0000_0000, v);
      end
      wr(SPCR_OFF_ROUTING, 4'b0010, 32'h0000_0000);
      wr(SPCR_OFF_COUNTER, 4'hf, 32'hffff_fffe);
      repeat (2)
      begin
         tick;
         rx_pkt = 3'b001;
         tick;
         rx_pkt = 3'b000;
      end
      rd(SPCR_OFF_COUNTER, v);
      chk_val("saturated", 32'hffff_ffff, v);
      tick;
      cfg_rd = 1;
      rx_pkt = 3'b001;
      tick;
      cfg_rd = 0;
      rx_pkt = 3'b000;
      chk_val("clash read", 32'h0000_0000, cfg_rdata);
      rd(SPCR_OFF_COUNTER, v);
      chk_val("kept increment", 32'h0000_0001, v);
      $display("test counters done");
      // Range windows, absent pairs, decode and translation
      for (int d = 0; d < 4; d++)
         for (int p = 1; p < 6; p += 4)
         begin
            m = $urandom;
            set_win(p, d);
            wr(SPCR_OFF_RANGE, 4'hf, m);
            rd(SPCR_OFF_RANGE, v);
            chk_val("range data", exp_win(p, d, m), v);
         end
      for (int d = 0; d < 4; d++)
      begin
         set_win(1, d);
         wr(SPCR_OFF_RANGE, 4'hf, rng[d]);
      end
      set_win(1, 0);
      wr(SPCR_OFF_XLATE, 4'hf, 32'h0000_0001);
      set_win(1, 2);
      wr(SPCR_OFF_XLATE, 4'hf, 32'h0000_0002);
      wr(SPCR_OFF_ROUTING, 4'b0001, 32'h0000_0020);
      req_addr = 64'h0000_0001_0080_0000;
      tick;
      chk_bit("range hit", 1, range_hit[1]);
      chk_val("xlate", 64'h0000_0002_0080_0000, xlate_addr);
      req_addr = 64'h0000_0001_0100_0000;
      tick;
      chk_bit("above limit", 0, range_hit[1]);
      req_addr = 64'h0000_0001_0080_0000;
      set_win(1, 0);
      wr(SPCR_OFF_RANGE, 4'hf, 32'h0000_0000);
      chk_bit("range off", 0, range_hit[1]);
      $display("test ranges done");
      tally_and_finish;
   end
endmodule
